//--- hw/ecp_pkg.sv
// Shared constants for the edge capture unit with auxiliary PWM output.
// Assumes a single system clock and plain control ports, with no register bus.
package ecp_pkg;

    // ==========================================================
    // Widths
    localparam int CTR_W = 32;
    localparam int PRESCALE_W = 5;
    localparam int SEQ_W = 2;
    localparam int NUM_EVENTS = 4;
    localparam int FLAG_W = 8;

    // ==========================================================
    // Event flag layout (shared by enable, flag, clear and force words)
    localparam int FLG_GLOBAL = 0;
    localparam int FLG_EVT_FIRST = 1;
    localparam int FLG_OVERFLOW = 5;
    localparam int FLG_PERIOD = 6;
    localparam int FLG_COMPARE = 7;

    // ==========================================================
    // Reset values and counter wrap point
    localparam logic [CTR_W-1:0] CTR_RESET = 32'h0000_0000;
    localparam logic [CTR_W-1:0] CTR_ALL_ONES = 32'hFFFF_FFFF;
    localparam logic [CTR_W-1:0] SLOT_RESET = 32'h0000_0000;
    localparam logic [FLAG_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [SEQ_W-1:0] SEQ_RESET = 2'h0;
    localparam logic [PRESCALE_W-1:0] PRESCALE_BYPASS = 5'h00;

    // ==========================================================
    // Mode codes
    localparam logic MODE_CAPTURE = 1'b0;
    localparam logic MODE_PWM = 1'b1;
    localparam logic POL_ACTIVE_HIGH = 1'b0;
    localparam logic EDGE_RISING = 1'b0;

endpackage

//--- hw/ecp_prescaler.sv
// Event prescaler: divides the capture pulse train by 2*field, or passes it.
// Assumes the input level is synchronous to sys_clk.
module ecp_prescaler
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Configuration
    input wire logic [ecp_pkg::PRESCALE_W-1:0] prescale,
    // Signal
    input wire logic pin_level,
    output logic scaled_level
);

    // ==========================================================
    // Change detection and first-edge mask
    logic [ecp_pkg::PRESCALE_W-1:0] prescale_q;
    logic pin_q;
    logic mask;
    logic div_level;
    logic [ecp_pkg::PRESCALE_W-1:0] edge_cnt;
    logic pin_rise;
    logic cfg_change;
    logic swallow;

    assign pin_rise = pin_level & ~pin_q;
    assign cfg_change = (prescale != prescale_q);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            prescale_q <= ecp_pkg::PRESCALE_BYPASS;
            pin_q <= 1'b0;
            swallow <= 1'b0;
        end
        else
        begin
            prescale_q <= prescale;
            pin_q <= pin_level;
            swallow <= pin_level & (swallow | (mask & ~pin_q));
        end
    end

    // The edge after a change is swallowed so a half-counted ratio never leaks
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mask <= 1'b0;
        else if (cfg_change)
            mask <= 1'b1;
        else if (pin_rise)
            mask <= 1'b0;
    end

    // ==========================================================
    // Divider: toggles every field rising edges, ratio 2*field
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            edge_cnt <= ecp_pkg::PRESCALE_BYPASS;
            div_level <= 1'b0;
        end
        else if (cfg_change)
        begin
            edge_cnt <= ecp_pkg::PRESCALE_BYPASS;
            div_level <= 1'b0;
        end
        else if (pin_rise && !mask)
        begin
            if (edge_cnt == prescale - 5'h01)
            begin
                edge_cnt <= ecp_pkg::PRESCALE_BYPASS;
                div_level <= ~div_level;
            end
            else
                edge_cnt <= edge_cnt + 5'h01;
        end
    end

    // Bypass drops the whole first pulse
    assign scaled_level = (prescale == ecp_pkg::PRESCALE_BYPASS) ?
        (pin_level & ~swallow & ~(mask & ~pin_q)) : div_level;
endmodule

//--- hw/ecp_capture.sv
// Edge capture unit: time-stamps edges on one pin, or drives one PWM output.
// Assumes all control inputs are synchronous to sys_clk and write inputs are
// one-cycle pulses; the pin is shared and the enclosing pad resolves direction.

// How it works
// - Capture pulse train is divided by an even ratio 2..62 or passed through.
// - Prescale field zero bypasses the divider and feeds edge selectors directly.
// - First rising edge after a prescale change is dropped; ratio applies afterwards.
// - Each of four events has its own rising or falling edge select.
// - A slot takes the time-stamp as its load strobe ends.
// - Two-bit sequencer steps 0,1,2,3,0 on each qualified event unless stopped.
// - One-shot mode halts the sequencer and blocks loads when it equals stop value.
// - After one-shot stop, per-event counter reset still clears the counter until re-arm.
// - Re-arm zeroes the sequencer and allows loads again if load enable set.
// - Continuous mode ignores the stop value; slots fill as a circular buffer.
// - Counter counts each clock; hardware or forced sync loads the phase value.
// - With counter reset enabled for an event, capture first then clear to zero.
// - One-shot stop automatically clears the capture load enable bit.
// - PWM mode uses slot one/two as period/compare, three/four as shadows.
// - Seven latched events: four captures, overflow, period match, compare match.
// - Interrupt pulse when an enabled flag is set and global flag clear; sets global.
// - Force word sets event flags as if the event happened.
// - Capture flags only in capture mode; match flags only in PWM; overflow always.
// - No shadow loads in capture mode; PWM loads immediately or at period match.
// - PWM write to an active slot also writes its shadow.
// - Output high for compare cycles, full period at PERIOD+1 or more; polarity inverts.
module ecp_capture
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Shared pin
    input wire logic capture_pin_in,
    output logic pwm_out,
    output logic pwm_oe,
    // Mode and capture configuration
    input wire logic capture_or_pwm_select,
    input wire logic [ecp_pkg::PRESCALE_W-1:0] prescale,
    input wire logic [ecp_pkg::NUM_EVENTS-1:0] edge_falling_select,
    input wire logic [ecp_pkg::NUM_EVENTS-1:0] counter_reset_on_event,
    input wire logic one_shot_mode,
    input wire logic [ecp_pkg::SEQ_W-1:0] stop_value,
    input wire logic strobe_a,
    input wire logic load_enable_write,
    input wire logic load_enable_wdata,
    output logic capture_load_enable,
    output logic [ecp_pkg::SEQ_W-1:0] event_sequencer,
    output logic sequencer_stopped,
    // Counter and sync
    input wire logic sync_in,
    input wire logic sync_enable,
    input wire logic sync_force,
    input wire logic [ecp_pkg::CTR_W-1:0] phase_value,
    input wire logic counter_write,
    input wire logic [ecp_pkg::CTR_W-1:0] counter_wdata,
    output logic [ecp_pkg::CTR_W-1:0] time_stamp_counter,
    // Slot access
    input wire logic [ecp_pkg::NUM_EVENTS-1:0] slot_write,
    input wire logic [ecp_pkg::CTR_W-1:0] slot_wdata,
    output logic [ecp_pkg::CTR_W-1:0] capture_slot_one,
    output logic [ecp_pkg::CTR_W-1:0] capture_slot_two,
    output logic [ecp_pkg::CTR_W-1:0] capture_slot_three,
    output logic [ecp_pkg::CTR_W-1:0] capture_slot_four,
    // PWM configuration
    input wire logic shadow_immediate,
    input wire logic output_polarity_select,
    // Event flags
    input wire logic [ecp_pkg::FLAG_W-1:0] event_enable_register,
    input wire logic event_clear_write,
    input wire logic [ecp_pkg::FLAG_W-1:0] event_clear_register,
    input wire logic event_force_write,
    input wire logic [ecp_pkg::FLAG_W-1:0] event_force_register,
    output logic [ecp_pkg::FLAG_W-1:0] event_flag_register,
    output logic interrupt_pulse
);

    // ==========================================================
    // Prescale and edge qualification
    logic scaled_level;
    logic scaled_q;
    logic edge_rise;
    logic edge_fall;
    logic edge_hit;
    logic capture_mode;
    logic cap_event;
    logic seq_live;
    logic load_strobe;
    logic stop_hit;
    logic ctr_clear;
    logic [ecp_pkg::NUM_EVENTS-1:0] slot_load_strobes;

    ecp_prescaler u_prescaler
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .prescale(prescale),
        .pin_level(capture_pin_in),
        .scaled_level(scaled_level)
    );

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            scaled_q <= 1'b0;
        else
            scaled_q <= scaled_level;
    end

    assign capture_mode = (capture_or_pwm_select == ecp_pkg::MODE_CAPTURE);
    assign edge_rise = scaled_level & ~scaled_q;
    assign edge_fall = ~scaled_level & scaled_q;
    // Polarity is chosen per sequencer state, so each event has its own edge
    assign edge_hit = (edge_falling_select[event_sequencer] == ecp_pkg::EDGE_RISING) ?
        edge_rise : edge_fall;
    assign cap_event = capture_mode & edge_hit;
    assign seq_live = cap_event & ~sequencer_stopped;
    assign load_strobe = seq_live & capture_load_enable;
    assign stop_hit = seq_live & one_shot_mode & (event_sequencer == stop_value);
    // Counter reset keeps acting after a one-shot stop, until re-arm
    assign ctr_clear = cap_event & counter_reset_on_event[event_sequencer];

    genvar gi;
    generate
        for (gi = 0; gi < ecp_pkg::NUM_EVENTS; gi++)
        begin : g_strobe
            assign slot_load_strobes[gi] =
                load_strobe & (event_sequencer == ecp_pkg::SEQ_W'(gi));
        end
    endgenerate

    // ==========================================================
    // Sequencer and one-shot control
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            event_sequencer <= ecp_pkg::SEQ_RESET;
            sequencer_stopped <= 1'b0;
        end
        else if (strobe_a)
        begin
            event_sequencer <= ecp_pkg::SEQ_RESET;
            sequencer_stopped <= 1'b0;
        end
        else if (stop_hit)
            sequencer_stopped <= 1'b1;
        else if (seq_live)
            event_sequencer <= event_sequencer + 2'h1;
    end

    // Hardware stop overrides a software write in the same cycle
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_load_enable <= 1'b0;
        else if (stop_hit)
            capture_load_enable <= 1'b0;
        else if (load_enable_write)
            capture_load_enable <= load_enable_wdata;
    end

    // ==========================================================
    // Time-stamp counter
    logic sync_evt;
    logic pwm_mode;
    logic period_match;
    logic compare_match;
    logic overflow_evt;

    assign pwm_mode = ~capture_mode;
    assign sync_evt = sync_force | (sync_in & sync_enable);
    assign period_match = pwm_mode & (time_stamp_counter == capture_slot_one);
    assign compare_match = pwm_mode & (time_stamp_counter == capture_slot_two);
    assign overflow_evt = ~sync_evt & ~counter_write & ~ctr_clear & ~period_match &
        (time_stamp_counter == ecp_pkg::CTR_ALL_ONES);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            time_stamp_counter <= ecp_pkg::CTR_RESET;
        else if (sync_evt)
            time_stamp_counter <= phase_value;
        else if (counter_write)
            time_stamp_counter <= counter_wdata;
        else if (ctr_clear || period_match)
            time_stamp_counter <= ecp_pkg::CTR_RESET;
        else
            time_stamp_counter <= time_stamp_counter + 32'h0000_0001;
    end

    // ==========================================================
    // Capture slots and PWM shadows
    // A slot samples the counter on the edge that ends its strobe cycle, the
    // same edge on which the counter clears, so the old value is kept
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_slot_one <= ecp_pkg::SLOT_RESET;
        else if (slot_load_strobes[0])
            capture_slot_one <= time_stamp_counter;
        else if (slot_write[0])
            capture_slot_one <= slot_wdata;
        else if (pwm_mode && slot_write[2] && shadow_immediate)
            capture_slot_one <= slot_wdata;
        else if (pwm_mode && period_match && !shadow_immediate)
            capture_slot_one <= capture_slot_three;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_slot_two <= ecp_pkg::SLOT_RESET;
        else if (slot_load_strobes[1])
            capture_slot_two <= time_stamp_counter;
        else if (slot_write[1])
            capture_slot_two <= slot_wdata;
        else if (pwm_mode && slot_write[3] && shadow_immediate)
            capture_slot_two <= slot_wdata;
        else if (pwm_mode && period_match && !shadow_immediate)
            capture_slot_two <= capture_slot_four;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_slot_three <= ecp_pkg::SLOT_RESET;
        else if (slot_load_strobes[2])
            capture_slot_three <= time_stamp_counter;
        else if (slot_write[2] || (pwm_mode && slot_write[0]))
            capture_slot_three <= slot_wdata;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            capture_slot_four <= ecp_pkg::SLOT_RESET;
        else if (slot_load_strobes[3])
            capture_slot_four <= time_stamp_counter;
        else if (slot_write[3] || (pwm_mode && slot_write[1]))
            capture_slot_four <= slot_wdata;
    end

    // ==========================================================
    // PWM output
    // Comparison is on the current count, so compare N gives N high cycles
    // and any compare above the period keeps the output high throughout
    logic pwm_active;
    assign pwm_active = (time_stamp_counter < capture_slot_two);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pwm_out <= 1'b0;
        else if (!pwm_mode)
            pwm_out <= 1'b0;
        else if (output_polarity_select == ecp_pkg::POL_ACTIVE_HIGH)
            pwm_out <= pwm_active;
        else
            pwm_out <= ~pwm_active;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pwm_oe <= 1'b0;
        else
            pwm_oe <= pwm_mode;
    end

    // ==========================================================
    // Event flags and interrupt pulse
    logic [ecp_pkg::FLAG_W-1:0] hw_events;
    logic [ecp_pkg::FLAG_W-1:0] force_bits;
    logic [ecp_pkg::FLAG_W-1:0] clear_bits;
    logic [ecp_pkg::FLAG_W-1:0] next_flags;
    logic fire;

    always_comb
    begin
        hw_events = ecp_pkg::FLAGS_RESET;
        for (int i = 0; i < ecp_pkg::NUM_EVENTS; i++)
            hw_events[ecp_pkg::FLG_EVT_FIRST + i] =
                seq_live & (event_sequencer == i[ecp_pkg::SEQ_W-1:0]);
        hw_events[ecp_pkg::FLG_OVERFLOW] = overflow_evt;
        hw_events[ecp_pkg::FLG_PERIOD] = period_match;
        hw_events[ecp_pkg::FLG_COMPARE] = compare_match;
    end

    // The global bit cannot be forced; it is only set by a pulse
    assign force_bits = event_force_write ?
        (event_force_register & ~8'h01) : ecp_pkg::FLAGS_RESET;
    assign clear_bits = event_clear_write ? event_clear_register : ecp_pkg::FLAGS_RESET;
    assign fire = (|(event_flag_register & event_enable_register & ~8'h01)) &
        ~event_flag_register[ecp_pkg::FLG_GLOBAL];

    always_comb
    begin
        next_flags = (event_flag_register & ~clear_bits) | hw_events | force_bits;
        if (fire)
            next_flags[ecp_pkg::FLG_GLOBAL] = 1'b1;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            event_flag_register <= ecp_pkg::FLAGS_RESET;
        else
            event_flag_register <= next_flags;
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            interrupt_pulse <= 1'b0;
        else
            interrupt_pulse <= fire;
    end

endmodule

//--- test/ecp_pin_model.sv
// Pulse train source at the far side of the capture pin.
// Assumes the bench puts it on the pin only while the unit does not drive.
module ecp_pin_model
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control
    input wire logic run,
    input wire logic [7:0] high_len,
    input wire logic [7:0] low_len,
    // Pin
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left;
    // Idle pin rests low; a run starts with a rising edge
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst || !run)
        begin
            pin <= 1'b0;
            left <= 8'h01;
        end
        else if (left == 8'h01)
        begin
            pin <= !pin;
            left <= pin ? low_len : high_len;
        end
        else
            left <= left - 8'h01;
    end
endmodule

//--- test/ecp_capture_asserts.sv
// Concurrent checks on the ports of the edge capture unit.
// Assumes one clock domain; bound from the foot of this file.
module ecp_capture_asserts
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Watched ports
    input wire logic capture_or_pwm_select,
    input wire logic one_shot_mode,
    input wire logic strobe_a,
    input wire logic capture_load_enable,
    input wire logic [1:0] event_sequencer,
    input wire logic sequencer_stopped,
    input wire logic sync_force,
    input wire logic [31:0] phase_value,
    input wire logic [31:0] time_stamp_counter,
    input wire logic [31:0] capture_slot_two,
    input wire logic output_polarity_select,
    input wire logic pwm_out,
    input wire logic [7:0] event_flag_register,
    input wire logic interrupt_pulse
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    // ==========
    // Sequencer
    sequence s_zeroed;
        event_sequencer == 2'h0 && !sequencer_stopped;
    endsequence
    seq_step_a: assert property ($changed(event_sequencer) |->
        event_sequencer == $past(event_sequencer) + 2'h1 || $past(strobe_a))
        else $error("sequencer jumped");
    stop_hold_a: assert property (sequencer_stopped && !strobe_a |=>
        $stable(event_sequencer)) else $error("stopped sequencer moved");
    stop_clear_a: assert property ($rose(sequencer_stopped) |->
        !capture_load_enable) else $error("load enable kept at stop");
    strobe_a_zero_a: assert property (strobe_a |=> s_zeroed)
        else $error("re-arm did not zero");
    cont_run_a: assert property (!one_shot_mode && !sequencer_stopped |=>
        !sequencer_stopped) else $error("continuous mode stopped");
    // ==========
    // Counter, flags and output
    sync_load_a: assert property (sync_force |=>
        time_stamp_counter == $past(phase_value)) else $error("sync not loaded");
    ovf_flag_a: assert property ($past(time_stamp_counter) == 32'hFFFF_FFFF &&
        time_stamp_counter == 32'h0 |-> event_flag_register[5]) else $error("no overflow flag");
    int_once_a: assert property (interrupt_pulse |->
        event_flag_register[0] && !$past(event_flag_register[0])) else $error("bad pulse");
    cap_flag_a: assert property ($rose(event_flag_register[1]) |->
        !$past(capture_or_pwm_select)) else $error("capture flag in pwm");
    pwm_level_a: assert property (capture_or_pwm_select && $past(capture_or_pwm_select) |->
        pwm_out == (($past(time_stamp_counter) < $past(capture_slot_two))
        ^ $past(output_polarity_select))) else $error("pwm level wrong");
endmodule

bind ecp_capture ecp_capture_asserts u_ecp_capture_asserts
(
    .sys_clk, .rst, .capture_or_pwm_select, .one_shot_mode, .strobe_a, .capture_load_enable,
    .event_sequencer, .sequencer_stopped, .sync_force, .phase_value, .time_stamp_counter,
    .capture_slot_two, .output_polarity_select, .pwm_out, .event_flag_register,
    .interrupt_pulse
);

//--- test/testbench.sv
// Self-checking bench for the edge capture unit and its PWM output.
// Assumes the pin model drives the pin while the unit does not.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk, rst, capture_pin_in, pwm_out, pwm_oe, capture_or_pwm_select, one_shot_mode;
    logic strobe_a, load_enable_write, load_enable_wdata, capture_load_enable, sequencer_stopped;
    logic sync_in, sync_enable, sync_force, counter_write, shadow_immediate, interrupt_pulse;
    logic output_polarity_select, event_clear_write, event_force_write, run, model_pin;
    logic [4:0] prescale;
    logic [3:0] edge_falling_select, counter_reset_on_event, slot_write;
    logic [1:0] stop_value, event_sequencer;
    logic [31:0] phase_value, counter_wdata, time_stamp_counter, slot_wdata;
    logic [31:0] capture_slot_one, capture_slot_two, capture_slot_three, capture_slot_four;
    logic [7:0] event_enable_register, event_clear_register, event_force_register;
    logic [7:0] event_flag_register, high_len, low_len;
    int mismatches, compares, k, c, p, n;

    assign capture_pin_in = pwm_oe ? pwm_out : model_pin;

    ecp_capture u_ecp_capture
    (
        .sys_clk, .rst, .capture_pin_in, .pwm_out, .pwm_oe, .capture_or_pwm_select,
        .prescale, .edge_falling_select, .counter_reset_on_event, .one_shot_mode,
        .stop_value, .strobe_a, .load_enable_write, .load_enable_wdata,
        .capture_load_enable, .event_sequencer, .sequencer_stopped, .sync_in,
        .sync_enable, .sync_force, .phase_value, .counter_write, .counter_wdata,
        .time_stamp_counter, .slot_write, .slot_wdata, .capture_slot_one,
        .capture_slot_two, .capture_slot_three, .capture_slot_four, .shadow_immediate,
        .output_polarity_select, .event_enable_register, .event_clear_write,
        .event_clear_register, .event_force_write, .event_force_register,
        .event_flag_register, .interrupt_pulse
    );
    ecp_pin_model u_ecp_pin_model
    (
        .sys_clk, .rst, .run, .high_len, .low_len, .pin(model_pin)
    );

    // ==========
    // Helpers
    task automatic tick(int cycles = 1);
        repeat (cycles) @(posedge sys_clk);
        #1;
    endtask
    task automatic check(logic [31:0] seen, logic [31:0] expd);
        compares++;
        if (seen !== expd)
        begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic put_slot(int i, logic [31:0] v);
        slot_write[i] = 1'b1;
        slot_wdata = v;
        tick();
        slot_write = 4'h0;
        tick();
    endtask
    task automatic flag_op(logic frc, logic [7:0] v);
        event_force_write = frc;
        event_clear_write = !frc;
        event_force_register = v;
        event_clear_register = v;
        tick();
        event_force_write = 1'b0;
        event_clear_write = 1'b0;
    endtask
    task automatic wait_pulse;
        for (int i = 0; i < 8 && interrupt_pulse !== 1'b1; i++)
            tick();
    endtask
    function automatic logic [31:0] slot_of(int i);
        case (i)
            0: return capture_slot_one;
            1: return capture_slot_two;
            2: return capture_slot_three;
            default: return capture_slot_four;
        endcase
    endfunction
    // Expected delta; odd events are falling
    function automatic logic [31:0] exp_slot(int ps, int h, int l, int i);
        if (ps == 0)
            return (i % 2 == 1) ? h - 1 : l - 1;
        return ps * (h + l) - 1;
    endfunction

    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Tests take at most about 7300 cycles; allow 20000
    initial
    begin
        #160000;
        mismatches++;
        complete_run();
    end

    // ==========
    // Tests
    initial
    begin
        {capture_or_pwm_select, one_shot_mode, strobe_a, load_enable_write, load_enable_wdata,
            sync_in, sync_enable, sync_force, counter_write, shadow_immediate, run, prescale,
            output_polarity_select, event_clear_write, event_force_write, stop_value,
            edge_falling_select, counter_reset_on_event, slot_write} = '0;
        {phase_value, counter_wdata, slot_wdata, event_enable_register, event_clear_register,
            event_force_register, high_len, low_len} = '0;
        mismatches = 0;
        compares = 0;
        rst = 1'b1;
        n = $urandom(27237);
        tick(6);
        rst = 1'b0;
        load_enable_wdata = 1'b1;
        load_enable_write = 1'b1;
        tick();
        load_enable_write = 1'b0;
        counter_reset_on_event = 4'hF;
        edge_falling_select = 4'hA;
        run = 1'b1;
        for (int t = 0; t < 5; t++)
        begin
            k = (t == 0) ? 0 : (t == 1) ? 31 : $urandom_range(0, 4);
            high_len = $urandom_range(3, 10);
            low_len = $urandom_range(3, 10);
            prescale = k;
            tick((k + 1) * (high_len + low_len) * 7 + 40);
            for (int i = 0; i < 4; i++)
                check(slot_of(i), exp_slot(k, high_len, low_len, i));
            check(event_flag_register[4:1], 4'hF);
            $display("capture test with prescale %0d done", k);
        end
        run = 1'b0;
        prescale = 5'h00;
        tick(4);
        one_shot_mode = 1'b1;
        stop_value = $urandom_range(0, 3);
        for (int i = 0; i < 4; i++)
            put_slot(i, 32'h0000_00A5);
        strobe_a = 1'b1;
        tick();
        strobe_a = 1'b0;
        run = 1'b1;
        tick(120);
        check(sequencer_stopped, 1'b1);
        check(capture_load_enable, 1'b0);
        check(time_stamp_counter < 20, 1'b1);
        for (int i = 1; i < 4; i++)
            check(slot_of(i), i <= stop_value ? exp_slot(0, high_len, low_len, i) : 32'hA5);
        $display("one-shot test with stop %0d done", stop_value);
        run = 1'b0;
        counter_reset_on_event = 4'h0;
        phase_value = $urandom;
        sync_force = 1'b1;
        tick();
        sync_force = 1'b0;
        check(time_stamp_counter, phase_value);
        phase_value = $urandom;
        sync_enable = 1'b1;
        sync_in = 1'b1;
        tick();
        sync_in = 1'b0;
        tick(3);
        check(time_stamp_counter, phase_value + 3);
        flag_op(1'b0, 8'hFF);
        counter_wdata = 32'hFFFF_FFFE;
        counter_write = 1'b1;
        tick();
        counter_write = 1'b0;
        tick(2);
        check(event_flag_register[5], 1'b1);
        $display("counter test done");
        event_enable_register = 8'h60;
        flag_op(1'b1, 8'h20);
        wait_pulse();
        check(interrupt_pulse, 1'b1);
        check(event_flag_register, 8'h21);
        flag_op(1'b1, 8'h40);
        n = 0;
        repeat (6)
        begin
            n += (interrupt_pulse === 1'b1);
            tick();
        end
        check(n, 0);
        flag_op(1'b0, 8'h21);
        wait_pulse();
        check(interrupt_pulse, 1'b1);
        check(event_flag_register, 8'h41);
        $display("interrupt test done");
        event_enable_register = 8'h00;
        flag_op(1'b0, 8'hFF);
        capture_or_pwm_select = 1'b1;
        counter_wdata = 32'h0;
        counter_write = 1'b1;
        tick();
        counter_write = 1'b0;
        p = $urandom_range(4, 12);
        put_slot(0, p);
        check(capture_slot_three, p);
        check(pwm_oe, 1'b1);
        for (int t = 0; t < 4; t++)
        begin
            c = (t == 0) ? 0 : (t == 1) ? p : (t == 2) ? p + 1 : $urandom_range(0, p + 3);
            output_polarity_select = t[0];
            put_slot(1, c);
            check(capture_slot_four, c);
            tick(p + 2);
            n = 0;
            repeat (p + 1)
            begin
                n += (pwm_out === 1'b1);
                tick();
            end
            k = (c > p + 1) ? p + 1 : c;
            check(n, t[0] ? p + 1 - k : k);
        end
        for (int i = 0; i < 20 && time_stamp_counter !== 32'h1; i++)
            tick();
        put_slot(3, 32'h2);
        check(capture_slot_two, c);
        tick(p + 1);
        check(capture_slot_two, 32'h2);
        shadow_immediate = 1'b1;
        put_slot(2, p + 3);
        check(capture_slot_one, p + 3);
        check(event_flag_register[7:6], 2'h3);
        check(event_flag_register[4:1], 4'h0);
        $display("pwm test with period %0d done", p);
        complete_run();
    end
endmodule
